// file: rtl/miv_prio.sv
// Fixed priority picker, lowest index wins
`timescale 1ns/1ns
`default_nettype none
module miv_prio #(
  parameter int W  = 32,
  parameter int IW = 5
) (
  // Requests
  input  wire logic [W-1:0]  req,
  // Result
  output var  logic          found,
  output var  logic [IW-1:0] idx
);

  // Walk downward so the lowest set bit is the last to win
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/miv_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module miv_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second; pins idle high (active low)
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_r   <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: rtl/miv_top.sv
// Interrupt and trap vectoring unit with Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module miv_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output var  logic [31:0] wb_dat_r,
  output var  logic        wb_ack,
  // On-chip maskable event pulses
  input  wire logic        float_invalid_irq,
  input  wire logic        float_div_zero_irq,
  input  wire logic        float_overflow_irq,
  input  wire logic        float_underflow_irq,
  input  wire logic        float_inexact_irq,
  input  wire logic        frame_timer_zero_irq,
  input  wire logic        frame_timer_one_irq,
  input  wire logic        periodic_count_irq,
  input  wire logic        mem_fault_irq,
  input  wire logic        int_overflow_irq,
  input  wire logic        slave_zero_msg_irq,
  input  wire logic        slave_one_msg_irq,
  input  wire logic        slave_two_msg_irq,
  input  wire logic        slave_three_msg_irq,
  input  wire logic        self_msg_irq,
  input  wire logic        pkt_done_irq,
  input  wire logic        pkt_busy_irq,
  input  wire logic        pkt_bad_irq,
  input  wire logic        slave_error_irq,
  // External interrupt pins, active low, asynchronous
  input  wire logic        ext_pin_one_n,
  input  wire logic        ext_pin_two_n,
  input  wire logic        ext_pin_three_n,
  input  wire logic        ext_pin_four_n,
  // Nonmaskable trap pulses
  input  wire logic        emu_trap_one,
  input  wire logic        emu_trap_two,
  input  wire logic        emu_trap_three,
  input  wire logic        emu_trap_four,
  input  wire logic        float_error_trap,
  input  wire logic        illegal_op_trap,
  // Software trap request
  input  wire logic        sw_trap_req,
  input  wire logic [8:0]  sw_trap_num,
  output var  logic        sw_trap_busy,
  // Vector to fetch logic
  output var  logic        vec_valid,
  output var  logic [31:0] vec_addr,
  output var  logic [8:0]  vec_num,
  output var  logic        vec_is_trap,
  input  wire logic        vec_ack,
  // Interrupt to software
  output var  logic        irq
);

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [3:0] pin_sync;
  logic [3:0] pin_dly_r;
  logic [3:0] pin_fall;

  miv_sync #(.W(4)) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({ext_pin_four_n, ext_pin_three_n, ext_pin_two_n, ext_pin_one_n}),
    .sync_out (pin_sync)
  );

  // Falling edge of a synced pin asserts the event once per assertion
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pin_dly_r <= 4'hf;
    else
      pin_dly_r <= pin_sync;
  end
  assign pin_fall = pin_dly_r & ~pin_sync;

  // ----------------------------------------------------------------
  // Event vector assembly
  // ----------------------------------------------------------------
  logic [31:0] src_evt;
  logic [7:0]  trap_evt;

  // Place each source on its fixed slot
  always_comb
  begin
    src_evt = 32'h0;
    src_evt[miv_pkg::FLT_INV_BIT]  = float_invalid_irq;
    src_evt[miv_pkg::FLT_DZ_BIT]   = float_div_zero_irq;
    src_evt[miv_pkg::FLT_OVF_BIT]  = float_overflow_irq;
    src_evt[miv_pkg::FLT_UNF_BIT]  = float_underflow_irq;
    src_evt[miv_pkg::FLT_INX_BIT]  = float_inexact_irq;
    src_evt[miv_pkg::FRM0_BIT]     = frame_timer_zero_irq;
    src_evt[miv_pkg::FRM1_BIT]     = frame_timer_one_irq;
    src_evt[miv_pkg::TMR_BIT]      = periodic_count_irq;
    src_evt[miv_pkg::MFLT_BIT]     = mem_fault_irq;
    src_evt[miv_pkg::IOVF_BIT]     = int_overflow_irq;
    src_evt[miv_pkg::SLV0_BIT]     = slave_zero_msg_irq;
    src_evt[miv_pkg::SLV0_BIT + 1] = slave_one_msg_irq;
    src_evt[miv_pkg::SLV0_BIT + 2] = slave_two_msg_irq;
    src_evt[miv_pkg::SLV0_BIT + 3] = slave_three_msg_irq;
    src_evt[miv_pkg::SELF_BIT]     = self_msg_irq;
    src_evt[miv_pkg::PKT_DONE_BIT] = pkt_done_irq;
    src_evt[miv_pkg::PKT_BUSY_BIT] = pkt_busy_irq;
    src_evt[miv_pkg::PKT_BAD_BIT]  = pkt_bad_irq;
    src_evt[miv_pkg::SLV_ERR_BIT]  = slave_error_irq;
    src_evt[miv_pkg::EXT1_BIT]     = pin_fall[0];
    src_evt[miv_pkg::EXT2_BIT]     = pin_fall[1];
    src_evt[miv_pkg::EXT3_BIT]     = pin_fall[2];
    src_evt[miv_pkg::EXT4_BIT]     = pin_fall[3];
  end

  // Hardware trap order; reserved traps 37 and 39 have no source
  assign trap_evt = {1'b0, illegal_op_trap, 1'b0, float_error_trap,
                     emu_trap_four, emu_trap_three, emu_trap_two, emu_trap_one};

  // ----------------------------------------------------------------
  // Registers and next values
  // ----------------------------------------------------------------
  logic [31:0]         en_r, en_nxt;
  logic [31:0]         pend_r, pend_nxt;
  logic [7:0]          trap_r, trap_nxt;
  logic                swt_r, swt_nxt;
  logic [8:0]          swt_num_r, swt_num_nxt;
  logic [2:0]          st_r, st_nxt;
  logic [2:0]          msk_r, msk_nxt;
  logic [31:0]         rdat_nxt;
  logic                ack_nxt;
  miv_pkg::miv_state_t state_r, state_nxt;
  logic                vv_nxt, vt_nxt;
  logic [8:0]          vn_nxt;
  logic [31:0]         va_nxt;
  logic                irq_nxt;

  logic        bus_req;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wmask;
  logic [31:0] mask_req;
  logic        msk_found;
  logic [4:0]  msk_idx;
  logic        trap_found;
  logic [2:0]  trap_idx;
  logic        sw_ok;

  assign bus_req = wb_cyc & wb_stb & ~wb_ack;
  assign wr_en   = bus_req & wb_we;
  assign rd_en   = bus_req & ~wb_we;
  assign wmask   = lane_mask(wb_sel);

  // Only sources with both enables compete
  assign mask_req = pend_r & en_r & {32{en_r[miv_pkg::GIE_BIT]}} & miv_pkg::SRC_MASK;

  // Lowest slot first among maskable and among traps
  miv_prio #(.W(32), .IW(5)) u_prio_msk (
    .req   (mask_req),
    .found (msk_found),
    .idx   (msk_idx)
  );
  miv_prio #(.W(8), .IW(3)) u_prio_trap (
    .req   (trap_r),
    .found (trap_found),
    .idx   (trap_idx)
  );

  assign sw_ok = (sw_trap_num >= miv_pkg::SW_TRAP_FIRST) &&
                 (sw_trap_num <= miv_pkg::SW_TRAP_LAST);

  // Bus, pending, trap latches and presentation
  always_comb
  begin
    en_nxt      = en_r;
    pend_nxt    = pend_r;
    trap_nxt    = trap_r | trap_evt;
    swt_nxt     = swt_r;
    swt_num_nxt = swt_num_r;
    msk_nxt     = msk_r;
    st_nxt      = st_r;
    rdat_nxt    = 32'h0;
    ack_nxt     = bus_req;
    state_nxt   = state_r;
    vv_nxt      = vec_valid;
    vt_nxt      = vec_is_trap;
    vn_nxt      = vec_num;
    va_nxt      = vec_addr;
    // Register writes, byte lanes honoured
    if (wr_en && wb_adr == miv_pkg::OFS_ENABLE)
      en_nxt = (en_r & ~wmask) | (wb_dat_w & wmask & (miv_pkg::SRC_MASK | 32'h1));
    if (wr_en && wb_adr == miv_pkg::OFS_MASK)
      msk_nxt = wb_sel[0] ? wb_dat_w[2:0] : msk_r;
    // Write-one clears; a new event in the same cycle stays set
    if (wr_en && wb_adr == miv_pkg::OFS_PENDING)
      pend_nxt = pend_r & ~(wb_dat_w & wmask);
    pend_nxt = pend_nxt | (src_evt & miv_pkg::SRC_MASK);
    // Reads; unmapped addresses answer zero
    if (rd_en)
    begin
      case (wb_adr)
        miv_pkg::OFS_ENABLE:  rdat_nxt = en_r;
        miv_pkg::OFS_PENDING: rdat_nxt = pend_r;
        miv_pkg::OFS_VECTOR:  rdat_nxt = vec_addr;
        miv_pkg::OFS_STATUS:  rdat_nxt = {29'h0, st_r};
        miv_pkg::OFS_MASK:    rdat_nxt = {29'h0, msk_r};
        default:              rdat_nxt = 32'h0;
      endcase
      if (wb_adr == miv_pkg::OFS_STATUS)
        st_nxt = 3'h0;
    end
    // One software trap held; refusals are reported
    if (sw_trap_req)
    begin
      if (sw_ok && !swt_r)
      begin
        swt_nxt     = 1'b1;
        swt_num_nxt = sw_trap_num;
      end
      else
        st_nxt[miv_pkg::ST_SW_REFUSED] = 1'b1;
    end
    case (state_r)
      miv_pkg::ST_IDLE:
      begin
        // Traps need no enable and outrank maskable slots
        if (trap_found)
        begin
          vv_nxt    = 1'b1;
          vt_nxt    = 1'b1;
          vn_nxt    = miv_pkg::HW_TRAP_FIRST + {6'h0, trap_idx};
          state_nxt = miv_pkg::ST_PRESENT;
          st_nxt[miv_pkg::ST_TRAP_TAKEN] = 1'b1;
        end
        else if (swt_r)
        begin
          vv_nxt    = 1'b1;
          vt_nxt    = 1'b1;
          vn_nxt    = swt_num_r;
          state_nxt = miv_pkg::ST_PRESENT;
          st_nxt[miv_pkg::ST_TRAP_TAKEN] = 1'b1;
        end
        else if (msk_found)
        begin
          vv_nxt    = 1'b1;
          vt_nxt    = 1'b0;
          vn_nxt    = {4'h0, msk_idx};
          state_nxt = miv_pkg::ST_PRESENT;
          st_nxt[miv_pkg::ST_MSK_TAKEN] = 1'b1;
        end
      end
      miv_pkg::ST_PRESENT:
      begin
        if (vec_ack)
        begin
          vv_nxt    = 1'b0;
          state_nxt = miv_pkg::ST_IDLE;
          // Taking a maskable slot drops the global enable to stop re-entry
          if (!vec_is_trap)
            en_nxt[miv_pkg::GIE_BIT] = 1'b0;
          else if (vec_num >= miv_pkg::SW_TRAP_FIRST)
            swt_nxt = 1'b0;
          else
            trap_nxt[vec_num[2:0]] = trap_evt[vec_num[2:0]];
        end
      end
      default:
      begin
        vv_nxt    = 1'b0;
        state_nxt = miv_pkg::ST_IDLE;
      end
    endcase
    // Vector word at base plus four per number
    va_nxt  = miv_pkg::VEC_BASE + {21'h0, vn_nxt, 2'b00};
    irq_nxt = |(st_nxt & msk_nxt);
  end

  // Register everything; outputs come straight from these flops
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      en_r         <= miv_pkg::RST_ENABLE;
      pend_r       <= 32'h0;
      trap_r       <= 8'h0;
      swt_r        <= 1'b0;
      swt_num_r    <= 9'h0;
      st_r         <= 3'h0;
      msk_r        <= miv_pkg::RST_MASK;
      wb_dat_r     <= 32'h0;
      wb_ack       <= 1'b0;
      state_r      <= miv_pkg::ST_IDLE;
      vec_valid    <= 1'b0;
      vec_is_trap  <= 1'b0;
      vec_num      <= 9'h0;
      vec_addr     <= miv_pkg::VEC_BASE;
      sw_trap_busy <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      en_r         <= en_nxt;
      pend_r       <= pend_nxt;
      trap_r       <= trap_nxt;
      swt_r        <= swt_nxt;
      swt_num_r    <= swt_num_nxt;
      st_r         <= st_nxt;
      msk_r        <= msk_nxt;
      wb_dat_r     <= rdat_nxt;
      wb_ack       <= ack_nxt;
      state_r      <= state_nxt;
      vec_valid    <= vv_nxt;
      vec_is_trap  <= vt_nxt;
      vec_num      <= vn_nxt;
      vec_addr     <= va_nxt;
      sw_trap_busy <= swt_nxt;
      irq          <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic pend_wr;
  assign pend_wr = wr_en && wb_adr == miv_pkg::OFS_PENDING;

  vec_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    vec_valid |-> vec_addr == 32'h0101_0180 + {21'h0, vec_num, 2'b00})
    else $error("vector address not base plus four times number");
  slot_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mem_fault_irq |=> pend_r[14] && (pend_r & 32'h01f0_2013) == 32'h0)
    else $error("fault slot or unused slot wrong");
  slave_err_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    slave_error_irq ##1 !pend_wr |=> pend_r[31])
    else $error("slave error slot lost");
  pin_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_fall[0] |=> pend_r[11])
    else $error("first pin did not set slot 11");
  pin_two_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(pin_sync[1]) |=> pend_r[12])
    else $error("second pin did not set slot 12");
  pin_three_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_fall[2] |=> pend_r[29])
    else $error("third pin did not set slot 29");
  pin_four_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pin_fall[3] |=> pend_r[30])
    else $error("fourth pin did not set slot 30");
  trap_nomask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trap_r != 8'h0 && !vec_valid |=> vec_valid && vec_is_trap && vec_num < 9'd40)
    else $error("nonmaskable trap not presented");
  sw_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    vec_valid && vec_num >= 9'd40 |-> vec_num >= 9'd72 && vec_num <= 9'd415)
    else $error("software trap number out of range");
  gie_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(vec_valid) && !vec_is_trap |->
      $past(en_r[0]) && (($past(en_r) >> vec_num[4:0]) & 32'h1) == 32'h1)
    else $error("maskable taken without enables");
  pend_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(pend_wr) |-> (pend_r & $past(pend_r)) == $past(pend_r))
    else $error("pending flag cleared without write");
  low_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(vec_valid) && !vec_is_trap |->
      ($past(mask_req) & ((32'h1 << vec_num[4:0]) - 32'h1)) == 32'h0)
    else $error("lower pending slot skipped");

endmodule
`default_nettype wire

// file: shared/miv_pkg.sv
// Shared constants for the interrupt and trap vectoring unit
package miv_pkg;

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam logic [31:0] VEC_BASE      = 32'h0101_0180;
  localparam int          NUM_W         = 9;
  localparam int          MSK_SLOTS     = 32;
  localparam int          HW_TRAPS      = 8;
  localparam logic [8:0]  HW_TRAP_FIRST = 9'h020;
  localparam logic [8:0]  SW_TRAP_FIRST = 9'h048;
  localparam logic [8:0]  SW_TRAP_LAST  = 9'h19f;

  // ----------------------------------------------------------------
  // Maskable slot positions
  // ----------------------------------------------------------------
  localparam int GIE_BIT      = 0;
  localparam int FLT_INV_BIT  = 2;
  localparam int FLT_DZ_BIT   = 3;
  localparam int FLT_OVF_BIT  = 5;
  localparam int FLT_UNF_BIT  = 6;
  localparam int FLT_INX_BIT  = 7;
  localparam int FRM0_BIT     = 8;
  localparam int FRM1_BIT     = 9;
  localparam int TMR_BIT      = 10;
  localparam int EXT1_BIT     = 11;
  localparam int EXT2_BIT     = 12;
  localparam int MFLT_BIT     = 14;
  localparam int IOVF_BIT     = 15;
  localparam int SLV0_BIT     = 16;
  localparam int SELF_BIT     = 25;
  localparam int PKT_DONE_BIT = 26;
  localparam int PKT_BUSY_BIT = 27;
  localparam int PKT_BAD_BIT  = 28;
  localparam int EXT3_BIT     = 29;
  localparam int EXT4_BIT     = 30;
  localparam int SLV_ERR_BIT  = 31;
  // Slots that hold a source; bit 0 is the global enable, not a source
  localparam logic [31:0] SRC_MASK = 32'hfe0f_dfec;

  // ----------------------------------------------------------------
  // Hardware trap offsets from the first trap number
  // ----------------------------------------------------------------
  localparam int TRAP_FLT_ERR = 4;
  localparam int TRAP_ILL_OP  = 6;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_ENABLE  = 8'h00;
  localparam logic [7:0]  OFS_PENDING = 8'h04;
  localparam logic [7:0]  OFS_VECTOR  = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_MASK    = 8'h10;
  localparam logic [31:0] RST_ENABLE  = 32'h0000_0000;
  localparam logic [2:0]  RST_MASK    = 3'h0;
  localparam int ST_MSK_TAKEN  = 0;
  localparam int ST_TRAP_TAKEN = 1;
  localparam int ST_SW_REFUSED = 2;

  // Presentation state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b01,
    ST_PRESENT = 2'b10
  } miv_state_t;

endpackage

// file: sim/miv_fetch_model.sv
// Fetch-side model that takes offered vectors after a chosen wait
`timescale 1ns/1ns
`default_nettype none
module miv_fetch_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Vector offer and acceptance
  input  wire logic       vec_valid,
  input  wire logic [2:0] wait_cyc,
  output var  logic       vec_ack
);
  logic [2:0] cnt_r;

  // Wait out the delay, then a one-cycle ack so each offer is taken once
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !vec_valid || vec_ack)
    begin
      cnt_r   <= 3'h0;
      vec_ack <= 1'b0;
    end
    else if (cnt_r == wait_cyc)
      vec_ack <= 1'b1;
    else
      cnt_r <= cnt_r + 3'h1;
  end
endmodule
`default_nettype wire

// file: sim/miv_top_tb_top.sv
// Self-checking bench for the vectoring unit
`timescale 1ns/1ns
`default_nettype none
module miv_top_tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc, wb_stb, wb_we, wb_ack, sw_trap_req, sw_trap_busy;
  logic        vec_valid, vec_is_trap, vec_ack, irq;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, pin_n;
  logic [31:0] wb_dat_w, wb_dat_r, vec_addr, rd_q, m;
  logic [31:0] seed;
  logic [8:0]  sw_trap_num, vec_num;
  logic [18:0] ev;
  logic [5:0]  trp;
  logic [2:0]  ack_dly;
  logic [41:0] vq[$];
  int          errors = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  int          a, b, lo, hi, n;
  int          slot_t[23] = '{2, 3, 5, 6, 7, 8, 9, 10, 14, 15, 16, 17, 18, 19, 25, 26, 27, 28,
                              31, 11, 12, 29, 30};
  int          trap_t[6] = '{32, 33, 34, 35, 36, 38};
  int          sw_t[5] = '{71, 416, 511, 72, 415};

  miv_top miv_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .float_invalid_irq(ev[0]), .float_div_zero_irq(ev[1]), .float_overflow_irq(ev[2]),
    .float_underflow_irq(ev[3]), .float_inexact_irq(ev[4]), .frame_timer_zero_irq(ev[5]),
    .frame_timer_one_irq(ev[6]), .periodic_count_irq(ev[7]), .mem_fault_irq(ev[8]),
    .int_overflow_irq(ev[9]), .slave_zero_msg_irq(ev[10]), .slave_one_msg_irq(ev[11]),
    .slave_two_msg_irq(ev[12]), .slave_three_msg_irq(ev[13]), .self_msg_irq(ev[14]),
    .pkt_done_irq(ev[15]), .pkt_busy_irq(ev[16]), .pkt_bad_irq(ev[17]), .slave_error_irq(ev[18]),
    .ext_pin_one_n(pin_n[0]), .ext_pin_two_n(pin_n[1]), .ext_pin_three_n(pin_n[2]),
    .ext_pin_four_n(pin_n[3]), .emu_trap_one(trp[0]), .emu_trap_two(trp[1]),
    .emu_trap_three(trp[2]), .emu_trap_four(trp[3]), .float_error_trap(trp[4]),
    .illegal_op_trap(trp[5]), .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
    .sw_trap_busy(sw_trap_busy), .vec_valid(vec_valid), .vec_addr(vec_addr),
    .vec_num(vec_num), .vec_is_trap(vec_is_trap), .vec_ack(vec_ack), .irq(irq));

  miv_fetch_model miv_fetch_model_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .vec_valid(vec_valid), .wait_cyc(ack_dly),
    .vec_ack(vec_ack));

  // Clock and hang limit; the limit is well above the thousand or so cycles used
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      errors++;
      final_report();
    end
  end

  // Record every vector at the edge the fetch side takes it
  always @(posedge ref_clk)
    if (vec_valid === 1'b1 && vec_ack === 1'b1)
      vq.push_back({vec_is_trap, vec_num, vec_addr});

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [41:0] exp_vec(input int v, input logic t);
    return {t, 9'(v), miv_pkg::VEC_BASE + 32'(4 * v)};
  endfunction

  task automatic chk(input logic [41:0] seen, input logic [41:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is seen, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int w;
    w = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= ad;
    wb_sel   <= 4'hf;
    wb_dat_w <= d;
    do
    begin
      @(posedge ref_clk);
      w++;
    end
    while (wb_ack !== 1'b1 && w < 64);
    // A missing answer counts as a mismatch
    chk(wb_ack, 1'b1);
    rd_q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(rd_q, e);
  endtask

  // Pins are held low three cycles so the two-stage sync sees the edge
  task automatic fire(input int i);
    if (i < 19)
      ev[i] <= 1'b1;
    else
      pin_n[i-19] <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ev    <= '0;
    pin_n <= 4'hf;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic vec(input int v, input logic t);
    int w;
    w = 0;
    while (vq.size() == 0 && w < 300)
    begin
      @(posedge ref_clk);
      w++;
    end
    chk((vq.size() > 0) ? vq.pop_front() : '1, exp_vec(v, t));
    @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {wb_cyc, wb_stb, wb_we, sw_trap_req, ev, trp, wb_adr, wb_sel, wb_dat_w} = '0;
    {sw_trap_num, ack_dly} = '0;
    pin_n = 4'hf;
    seed  = 32'ha62692d8;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk(vec_addr, miv_pkg::VEC_BASE);
    rd(miv_pkg::OFS_PENDING, 32'h0);
    rd(miv_pkg::OFS_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, miv_pkg::OFS_ENABLE, '1);
    rd(miv_pkg::OFS_ENABLE, miv_pkg::SRC_MASK | 32'h1);
    bus(1'b1, miv_pkg::OFS_ENABLE, 32'h0);
    // Every source lands in its own slot and stays until written one
    for (int i = 0; i < 23; i++)
    begin
      m = 32'h1 << slot_t[i];
      fire(i);
      rd(miv_pkg::OFS_PENDING, m);
      bus(1'b1, miv_pkg::OFS_PENDING, ~m);
      rd(miv_pkg::OFS_PENDING, m);
      bus(1'b1, miv_pkg::OFS_PENDING, m);
      rd(miv_pkg::OFS_PENDING, 32'h0);
    end
    // Two random sources pending: gating, then lowest slot first
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      a = seed[15:0] % 23;
      b = (a + 1 + seed[23:16] % 22) % 23;
      ack_dly <= seed[26:24];
      fire(a);
      fire(b);
      lo = (slot_t[a] < slot_t[b]) ? slot_t[a] : slot_t[b];
      hi = slot_t[a] ^ slot_t[b] ^ lo;
      m = (32'h1 << lo) | (32'h1 << hi);
      bus(1'b1, miv_pkg::OFS_ENABLE, m);
      repeat (8) @(posedge ref_clk);
      chk(vq.size(), 0);
      bus(1'b1, miv_pkg::OFS_ENABLE, m | 32'h1);
      vec(lo, 1'b0);
      rd(miv_pkg::OFS_ENABLE, m);
      bus(1'b1, miv_pkg::OFS_PENDING, 32'h1 << lo);
      bus(1'b1, miv_pkg::OFS_ENABLE, m | 32'h1);
      vec(hi, 1'b0);
      // The vector word stays readable after the offer is taken
      rd(miv_pkg::OFS_VECTOR, miv_pkg::VEC_BASE + 32'(4 * hi));
      bus(1'b1, miv_pkg::OFS_PENDING, 32'h1 << hi);
    end
    // Interrupt line: masked, unmasked, then cleared by reading status
    chk(irq, 1'b0);
    bus(1'b1, miv_pkg::OFS_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    rd(miv_pkg::OFS_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    // All hardware traps at once with the global enable off
    trp <= 6'h3f;
    @(posedge ref_clk);
    trp <= 6'h0;
    for (int t = 0; t < 6; t++)
      vec(trap_t[t], 1'b1);
    rd(miv_pkg::OFS_STATUS, 32'h2);
    // Software traps: numbers outside the range first, then boundaries and random
    for (int s = 0; s < 8; s++)
    begin
      seed = lfsr(seed);
      n = (s < 5) ? sw_t[s] : 72 + seed[15:0] % 344;
      sw_trap_num <= n[8:0];
      sw_trap_req <= 1'b1;
      @(posedge ref_clk);
      sw_trap_req <= 1'b0;
      @(posedge ref_clk);
      // Busy only for an accepted number
      chk(sw_trap_busy, n >= 72 && n <= 415);
      if (n >= 72 && n <= 415)
        vec(n, 1'b1);
      else
        rd(miv_pkg::OFS_STATUS, 32'h4);
      @(posedge ref_clk);
    end
    final_report();
  end
endmodule
`default_nettype wire
